// ---- core/ternary_search_host_interface.sv ----
/*
  command interpreter, ternary table, cascade arbitration and result path of one search engine.
  assumes clk is the double-rate master clock, phase_select_n toggles every edge, and the
  host holds each command and data word for both edges of a phase pair.
*/
// Summary of operation
// - code in bits 1:0, parameters above
// - command bus ignored unless valid strobe
// - all inputs sampled on clock rising edge
// - outputs change only while phase is low
// - low reset clears all internal state
// - entry has data and don't-care mask
// - lowest matching address wins
// - lowest cascade match drives result memory
// - result memory and flags delayed, aligned
// - data bit zero marks entry occupied
// - table full when every entry occupied and full_in high
// - acknowledge marks valid read data
// - end-of-burst marks final burst word
// - hit flag only from global winner
// - hit flag meaningful only when valid
// - shared bus carries key, address, data
// - shared memory strobes driven by one
// - 22-bit result memory address output
// - entries of 68, 136, 272 bits
// - all-ones code broadcasts; last device reads
module ternary_search_host_interface
  import tcam_pkg::*;
#(
  parameter int DEPTH = DEF_DEPTH,
  parameter int SEARCH_LAT = DEF_SEARCH_LAT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic phase_select_n,
  input wire logic [CMD_W-1:0] cmd,
  input wire logic command_valid_strobe,
  input wire logic [DQ_W-1:0] dq_in,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  input wire logic [ID_W-1:0] device_position_code,
  input wire logic last_device_bit,
  input wire logic [1:0] entry_width_mode,
  input wire logic upstream_hit,
  output logic local_hit_out,
  input wire logic full_in,
  output logic full_out,
  output logic table_full,
  output logic read_ack,
  output logic read_ack_oe,
  output logic end_of_burst_out,
  output logic end_of_burst_oe,
  output logic search_hit_flag,
  output logic search_hit_flag_oe,
  output logic search_hit_flag_valid,
  output logic search_hit_flag_valid_oe,
  output logic [RESULT_MEMORY_ADDRESS_W-1:0] result_memory_address,
  output logic sram_chip_enable_n,
  output logic sram_write_enable_n,
  output logic sram_oe
);
  localparam int AW = $clog2(DEPTH);

  // lowest set bit wins; returns {found, index}
  function automatic logic [AW:0] first_set(input logic [DEPTH-1:0] v);
    logic [AW:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, AW'(i)};
      end
    end
    return r;
  endfunction : first_set

  // ----------------------------------------
  // input sampling
  // ----------------------------------------
  logic [CMD_W-1:0] cmd_q;
  logic command_valid_strobe_q;
  logic [DQ_W-1:0] dq_q;
  logic upstream_hit_q;
  logic full_in_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmd_q <= '0;
      command_valid_strobe_q <= 1'b0;
      dq_q <= '0;
      upstream_hit_q <= 1'b0;
      full_in_q <= 1'b0;
    end else begin
      cmd_q <= cmd;
      command_valid_strobe_q <= command_valid_strobe;
      dq_q <= dq_in;
      upstream_hit_q <= upstream_hit;
      full_in_q <= full_in;
    end
  end

  // internal step on the low phase only
  logic tick;
  assign tick = ~phase_select_n;
  logic [1:0] code;
  logic [1:0] tgt;
  assign code = cmd_q[CODE_MSB:CODE_LSB];
  assign tgt = cmd_q[TGT_MSB:TGT_LSB];
  logic cmd_go;
  assign cmd_go = tick & command_valid_strobe_q;
  logic bcast;
  logic selected;
  logic read_sel;
  assign bcast = dq_q[ID_LSB+ID_W-1:ID_LSB] == ID_BROADCAST;
  assign selected = bcast | (dq_q[ID_LSB+ID_W-1:ID_LSB] == device_position_code);
  assign read_sel = selected & (~bcast | last_device_bit);

  // ----------------------------------------
  // ternary table and match
  // ----------------------------------------
  logic [DQ_W-1:0] data_mem [DEPTH];
  logic [DQ_W-1:0] mask_mem [DEPTH];
  logic [DEPTH-1:0] row_hit;
  logic [DEPTH-1:0] grp_hit;
  logic [DEPTH-1:0] empty_row;
  logic [1:0] gmask;
  logic [AW:0] hit_res;
  logic [AW:0] free_res;
  logic my_full;
  assign gmask = (entry_width_mode == MODE_X272) ? 2'h3 : (entry_width_mode == MODE_X136) ? 2'h1 : 2'h0;
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      // mask bit set makes the position don't-care
      row_hit[i] = ((data_mem[i] ^ dq_q) & ~mask_mem[i]) == '0;
      empty_row[i] = ~data_mem[i][OCC_BIT];
    end
    // wide entries need every row of the group to hit
    for (int i = 0; i < DEPTH; i++) begin
      grp_hit[i] = ((2'(i) & gmask) == 2'h0) && row_hit[i];
      for (int j = 1; j < 4; j++) begin
        if (2'(j) <= gmask) begin
          grp_hit[i] = grp_hit[i] && (i + j < DEPTH) && row_hit[(i + j) % DEPTH];
        end
      end
    end
  end
  assign hit_res = first_set(grp_hit);
  assign free_res = first_set(empty_row);
  assign my_full = ~free_res[AW];

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  state_e state;
  logic [AW-1:0] addr;
  logic [1:0] tgt_q;
  logic [CNT_W-1:0] cnt;
  logic burst;
  logic last_word;
  assign last_word = cnt == '0;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      addr <= '0;
      tgt_q <= TGT_DATA;
      cnt <= '0;
      burst <= 1'b0;
    end else if (tick) begin
      unique case (state)
        ST_IDLE: begin
          // address word on the shared bus
          addr <= dq_q[AW-1:0];
          tgt_q <= tgt;
          cnt <= cmd_q[BURST_MSB:BURST_LSB];
          burst <= cmd_q[BURST_MSB:BURST_LSB] != '0;
          if (cmd_go && tgt != TGT_SRAM) begin
            if (code == CODE_READ && read_sel) begin
              state <= ST_READ;
            end else if (code == CODE_WRITE && selected) begin
              state <= ST_WRITE;
            end
          end
        end
        ST_WRITE, ST_READ: begin
          addr <= addr + 1'b1;
          cnt <= cnt - 1'b1;
          if (last_word) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // learn goes to the first device with room
  logic learn_go;
  assign learn_go = (state == ST_IDLE) && cmd_go && code == CODE_LEARN && full_in_q && ~my_full;
  // reset of the whole table is costly in area but keeps occupancy known
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < DEPTH; i++) begin
        data_mem[i] <= '0;
        mask_mem[i] <= '0;
      end
    end else if (tick) begin
      if (state == ST_WRITE && tgt_q == TGT_DATA) begin
        data_mem[addr] <= dq_q;
      end else if (state == ST_WRITE && tgt_q == TGT_MASK) begin
        mask_mem[addr] <= dq_q;
      end else if (learn_go) begin
        data_mem[free_res[AW-1:0]] <= dq_q | DQ_W'(1) << OCC_BIT;
        mask_mem[free_res[AW-1:0]] <= '0;
      end
    end
  end

  // ----------------------------------------
  // search pipeline and cascade
  // ----------------------------------------
  logic [SEARCH_LAT-1:0] hit_pipe;
  logic [SEARCH_LAT-1:0] vld_pipe;
  logic [AW-1:0] idx_pipe [SEARCH_LAT];
  logic search_go;
  logic winner;
  assign search_go = (state == ST_IDLE) && cmd_go && code == CODE_SEARCH;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hit_pipe <= '0;
      vld_pipe <= '0;
      for (int i = 0; i < SEARCH_LAT; i++) begin
        idx_pipe[i] <= '0;
      end
    end else if (tick) begin
      hit_pipe <= {hit_pipe[SEARCH_LAT-2:0], search_go & hit_res[AW]};
      vld_pipe <= {vld_pipe[SEARCH_LAT-2:0], search_go};
      idx_pipe[0] <= hit_res[AW-1:0];
      for (int i = 1; i < SEARCH_LAT; i++) begin
        idx_pipe[i] <= idx_pipe[i-1];
      end
    end
  end
  assign winner = hit_pipe[SEARCH_LAT-1] & ~upstream_hit_q;

  // ----------------------------------------
  // output launch
  // ----------------------------------------
  logic pio_sram;
  assign pio_sram = (state == ST_IDLE) && cmd_go && tgt == TGT_SRAM
    && ((code == CODE_READ && read_sel) || (code == CODE_WRITE && selected));
  // outputs move on the low phase only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dq_out <= '0;
      dq_oe <= 1'b0;
      read_ack <= 1'b0;
      read_ack_oe <= 1'b0;
      end_of_burst_out <= 1'b0;
      end_of_burst_oe <= 1'b0;
    end else if (tick) begin
      dq_out <= (tgt_q == TGT_MASK) ? mask_mem[addr] : data_mem[addr];
      // acknowledge with array or memory read data
      dq_oe <= state == ST_READ;
      read_ack <= state == ST_READ || (pio_sram && code == CODE_READ);
      read_ack_oe <= state == ST_READ || (pio_sram && code == CODE_READ);
      end_of_burst_out <= state != ST_IDLE && burst && last_word;
      end_of_burst_oe <= state != ST_IDLE && burst && last_word;
    end
  end

  // a winning search outranks a direct memory access in the same step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      search_hit_flag <= 1'b0;
      search_hit_flag_oe <= 1'b0;
      search_hit_flag_valid <= 1'b0;
      search_hit_flag_valid_oe <= 1'b0;
      result_memory_address <= '0;
      sram_chip_enable_n <= 1'b1;
      sram_write_enable_n <= 1'b1;
      sram_oe <= 1'b0;
      local_hit_out <= 1'b0;
      full_out <= 1'b0;
      table_full <= 1'b0;
    end else if (tick) begin
      // flag from the global winner only
      search_hit_flag <= winner;
      search_hit_flag_oe <= winner;
      search_hit_flag_valid <= vld_pipe[SEARCH_LAT-1] & last_device_bit;
      search_hit_flag_valid_oe <= vld_pipe[SEARCH_LAT-1] & last_device_bit;
      local_hit_out <= hit_pipe[SEARCH_LAT-2];
      full_out <= my_full & full_in_q;
      table_full <= my_full & full_in_q;
      // one driver of the shared memory lines
      if (winner) begin
        result_memory_address <= {{(RESULT_MEMORY_ADDRESS_W-AW){1'b0}}, idx_pipe[SEARCH_LAT-1]};
        sram_chip_enable_n <= 1'b0;
        sram_write_enable_n <= 1'b1;
        sram_oe <= 1'b1;
      end else if (pio_sram) begin
        result_memory_address <= dq_q[RESULT_MEMORY_ADDRESS_W-1:0];
        sram_chip_enable_n <= 1'b0;
        sram_write_enable_n <= code != CODE_WRITE;
        sram_oe <= 1'b1;
      end else begin
        sram_chip_enable_n <= 1'b1;
        sram_write_enable_n <= 1'b1;
        sram_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_HOLD_HIGH_PHASE: assert property (phase_select_n |=> $stable({read_ack, dq_oe, sram_oe, search_hit_flag}))
    else $error("output moved on high phase");
  AST_NO_STROBE_IDLE: assert property ((state == ST_IDLE && tick && !command_valid_strobe_q) |=> state == ST_IDLE)
    else $error("sequencer left idle without strobe");
  AST_READ_DELIVER: assert property ((state == ST_IDLE && cmd_go && code == CODE_READ && read_sel
    && tgt != TGT_SRAM && !phase_select_n) |-> ##3 (read_ack && dq_oe))
    else $error("read data not acknowledged");
  AST_BCAST_QUIET: assert property ((state == ST_IDLE && cmd_go && code == CODE_READ && bcast
    && !last_device_bit) |=> state == ST_IDLE)
    else $error("non-last device answered broadcast read");
  AST_EOB_LAST: assert property ((end_of_burst_out && dq_oe) |-> read_ack)
    else $error("end of burst without read word");
  AST_WIN_FLAG: assert property ((tick && winner) |=> (search_hit_flag && sram_oe && !sram_chip_enable_n))
    else $error("winner did not raise flag and memory strobe");
  AST_LOSE_QUIET: assert property ((tick && upstream_hit_q) |=> !search_hit_flag_oe)
    else $error("losing device drove hit flag");
  AST_RELEASE: assert property (!sram_oe |-> (sram_chip_enable_n && sram_write_enable_n))
    else $error("memory strobe active while released");
  AST_FULL_CHAIN: assert property ((tick && !full_in_q) |=> !full_out)
    else $error("full raised with room upstream");
  AST_FLAG_VALID: assert property ((search_hit_flag && last_device_bit) |-> search_hit_flag_valid)
    else $error("flag without valid on last device");
  COV_SEARCH_WIN: cover property (tick && winner);
  COV_BURST_READ: cover property (end_of_burst_out && read_ack);
  COV_LEARN: cover property (learn_go);
  COV_SRAM_WRITE: cover property (sram_oe && !sram_write_enable_n);
endmodule : ternary_search_host_interface

// ---- include/tcam_pkg.sv ----
/*
  constants, field layout and state codes of the ternary search engine's host interface.
  assumes a single clock domain and a host that follows the command bus layout below.
*/
package tcam_pkg;
  // ----------------------------------------
  // bus widths
  // ----------------------------------------
  localparam int DQ_W = 68;
  localparam int CMD_W = 9;
  localparam int RESULT_MEMORY_ADDRESS_W = 22;
  localparam int ID_W = 5;
  localparam int CNT_W = 5;
  // ----------------------------------------
  // command bus fields
  // ----------------------------------------
  localparam int CODE_LSB = 0;
  localparam int CODE_MSB = 1;
  localparam int TGT_LSB = 2;
  localparam int TGT_MSB = 3;
  localparam int BURST_LSB = 4;
  localparam int BURST_MSB = 8;
  localparam logic [1:0] CODE_READ = 2'h0;
  localparam logic [1:0] CODE_WRITE = 2'h1;
  localparam logic [1:0] CODE_SEARCH = 2'h2;
  localparam logic [1:0] CODE_LEARN = 2'h3;
  localparam logic [1:0] TGT_DATA = 2'h0;
  localparam logic [1:0] TGT_MASK = 2'h1;
  localparam logic [1:0] TGT_SRAM = 2'h2;
  // ----------------------------------------
  // address word and entry layout
  // ----------------------------------------
  localparam int ID_LSB = 26;
  localparam logic [ID_W-1:0] ID_BROADCAST = 5'h1F;
  localparam int OCC_BIT = 0;
  localparam logic [1:0] MODE_X136 = 2'h1;
  localparam logic [1:0] MODE_X272 = 2'h2;
  localparam int DEF_DEPTH = 16384;
  localparam int DEF_SEARCH_LAT = 4;
  // ----------------------------------------
  // command sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } state_e;
endpackage : tcam_pkg

// ---- test/host_model.sv ----
/*
  host model: phase generator and command driver for the search engine.
  assumes one clock; the bench calls its tasks by hierarchical name.
*/
module host_model
  import tcam_pkg::*;
(
  input wire logic clk,
  output logic phase_select_n,
  output logic [CMD_W-1:0] cmd,
  output logic command_valid_strobe,
  output logic [DQ_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    phase_select_n = 1'b1;
    cmd = '0;
    command_valid_strobe = 1'b0;
    dq_in = '0;
  end
  always @(posedge clk) begin
    phase_select_n <= ~phase_select_n;
  end
  // tick edge: phase low when sampled
  task automatic tick(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (phase_select_n !== 1'b0) @(posedge clk);
    end
  endtask : tick
  // word held over a tick pair
  task automatic send(input logic [CMD_W-1:0] c, input logic [DQ_W-1:0] d, input logic v);
    tick(1);
    cmd <= c;
    dq_in <= d;
    command_valid_strobe <= v;
  endtask : send
  task automatic idle();
    tick(1);
    command_valid_strobe <= 1'b0;
    dq_in <= ~dq_in;
  endtask : idle
endmodule : host_model

// ---- test/tb.sv ----
/*
  self-checking bench of the search engine host interface.
  assumes host_model drives phase and commands; single device, x68 mode apart from one x136 check.
*/
module tb;
  import tcam_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  localparam int LAT = 4;
  typedef struct {logic [DQ_W-1:0] key; logic hit; logic [RESULT_MEMORY_ADDRESS_W-1:0] adr;} row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic upstream_hit = 1'b0;
  logic [ID_W-1:0] device_position_code = 5'h00;
  logic last_device_bit = 1'b1;
  logic [1:0] entry_width_mode = 2'h0;
  logic full_in = 1'b1;
  logic seen_local = 1'b0;
  logic phase_select_n, command_valid_strobe, dq_oe, local_hit_out, full_out, table_full;
  logic read_ack, read_ack_oe, end_of_burst_out, end_of_burst_oe, search_hit_flag, search_hit_flag_oe;
  logic search_hit_flag_valid, search_hit_flag_valid_oe, sram_chip_enable_n, sram_write_enable_n, sram_oe;
  logic [CMD_W-1:0] cmd;
  logic [DQ_W-1:0] dq_in, dq_out;
  logic [RESULT_MEMORY_ADDRESS_W-1:0] result_memory_address;
  int fails = 0;
  int tests_run = 0;
  // lowest match wins, masked nibble ignored
  row_s rows[4] = '{'{68'hA5, 1'b1, 22'h3}, '{68'h75, 1'b1, 22'h6}, '{68'h0F, 1'b0, 22'h0}, '{68'hA7, 1'b0, 22'h0}};
  always #10 clk = ~clk;
  host_model host_model_inst (.clk(clk), .phase_select_n(phase_select_n), .cmd(cmd),
    .command_valid_strobe(command_valid_strobe), .dq_in(dq_in));
  ternary_search_host_interface #(.DEPTH(DEPTH), .SEARCH_LAT(LAT)) ternary_search_host_interface_inst (
    .clk(clk), .nrst(nrst), .phase_select_n(phase_select_n), .cmd(cmd),
    .command_valid_strobe(command_valid_strobe), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .device_position_code(device_position_code), .last_device_bit(last_device_bit),
    .entry_width_mode(entry_width_mode),
    .upstream_hit(upstream_hit), .local_hit_out(local_hit_out), .full_in(full_in), .full_out(full_out),
    .table_full(table_full), .read_ack(read_ack), .read_ack_oe(read_ack_oe),
    .end_of_burst_out(end_of_burst_out), .end_of_burst_oe(end_of_burst_oe),
    .search_hit_flag(search_hit_flag), .search_hit_flag_oe(search_hit_flag_oe),
    .search_hit_flag_valid(search_hit_flag_valid), .search_hit_flag_valid_oe(search_hit_flag_valid_oe),
    .result_memory_address(result_memory_address), .sram_chip_enable_n(sram_chip_enable_n),
    .sram_write_enable_n(sram_write_enable_n), .sram_oe(sram_oe));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic results();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [DQ_W-1:0] seen, input logic [DQ_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk
  function automatic logic [CMD_W-1:0] mkcmd(input logic [1:0] c, input logic [1:0] t, input logic [4:0] b);
    return {b, t, c};
  endfunction : mkcmd
  function automatic logic [DQ_W-1:0] adr(input logic [ID_W-1:0] dev, input logic [RESULT_MEMORY_ADDRESS_W-1:0] a);
    return (DQ_W'(dev) << ID_LSB) | DQ_W'(a);
  endfunction : adr
  task automatic wr(input logic [1:0] t, input logic [RESULT_MEMORY_ADDRESS_W-1:0] row, input logic [DQ_W-1:0] d);
    host_model_inst.send(mkcmd(CODE_WRITE, t, 5'h0), adr(5'h00, row), 1'b1);
    host_model_inst.send(mkcmd(CODE_WRITE, t, 5'h0), d, 1'b0);
    host_model_inst.idle();
    host_model_inst.tick(2);
  endtask : wr
  task automatic rd(input logic [1:0] t, input logic [ID_W-1:0] dev, input logic [RESULT_MEMORY_ADDRESS_W-1:0] a, input logic [4:0] b);
    host_model_inst.send(mkcmd(CODE_READ, t, b), adr(dev, a), 1'b1);
    host_model_inst.idle();
  endtask : rd
  task automatic search(input logic [DQ_W-1:0] key, input logic v);
    host_model_inst.send(mkcmd(CODE_SEARCH, 2'h0, 5'h0), key, v);
    host_model_inst.idle();
    // local hit leads the flag by one tick
    host_model_inst.tick(LAT - 1);
    #1;
    seen_local = local_hit_out;
    host_model_inst.tick(1);
    #1;
  endtask : search
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("ce_n", DQ_W'(sram_chip_enable_n), 68'h1);
    chk("we_n", DQ_W'(sram_write_enable_n), 68'h1);
    chk("ack", DQ_W'(read_ack), 68'h0);
    chk("valid", DQ_W'(search_hit_flag_valid), 68'h0);
    wr(TGT_DATA, 22'h3, 68'hA5);
    wr(TGT_DATA, 22'h6, 68'h05);
    wr(TGT_MASK, 22'h6, 68'hF0);
    for (int i = 0; i < 4; i++) begin
      search(rows[i].key, 1'b1);
      chk("hit", DQ_W'(search_hit_flag), DQ_W'(rows[i].hit));
      chk("valid", DQ_W'(search_hit_flag_valid), 68'h1);
      chk("local_hit", DQ_W'(seen_local), DQ_W'(rows[i].hit));
      chk("ce_n", DQ_W'(sram_chip_enable_n), DQ_W'(!rows[i].hit));
      if (rows[i].hit) chk("result_memory_address", DQ_W'(result_memory_address), DQ_W'(rows[i].adr));
    end
    // paired rows must both match in x136
    @(posedge clk) entry_width_mode <= MODE_X136;
    search(68'h75, 1'b1);
    chk("hit", DQ_W'(search_hit_flag), 68'h0);
    search(68'h0, 1'b1);
    chk("hit", DQ_W'(search_hit_flag), 68'h1);
    chk("result_memory_address", DQ_W'(result_memory_address), 68'h0);
    @(posedge clk) entry_width_mode <= 2'h0;
    // broadcast read answered by last device
    rd(TGT_DATA, ID_BROADCAST, 22'h3, 5'h0);
    host_model_inst.tick(1);
    #1;
    chk("dq", dq_out, 68'hA5);
    chk("ack", DQ_W'(read_ack), 68'h1);
    chk("ack_oe", DQ_W'(read_ack_oe), 68'h1);
    chk("eob", DQ_W'(end_of_burst_out), 68'h0);
    rd(TGT_DATA, 5'h02, 22'h3, 5'h0);
    host_model_inst.tick(1);
    #1;
    chk("ack", DQ_W'(read_ack), 68'h0);
    chk("oe", DQ_W'(dq_oe), 68'h0);
    // own code 2 answers; broadcast quiet when not last
    @(posedge clk) device_position_code <= 5'h02;
    rd(TGT_DATA, 5'h02, 22'h3, 5'h0);
    host_model_inst.tick(1);
    #1;
    chk("dq", dq_out, 68'hA5);
    chk("ack", DQ_W'(read_ack), 68'h1);
    @(posedge clk) last_device_bit <= 1'b0;
    rd(TGT_DATA, ID_BROADCAST, 22'h3, 5'h0);
    host_model_inst.tick(1);
    #1;
    chk("ack", DQ_W'(read_ack), 68'h0);
    search(68'hA5, 1'b1);
    chk("hit", DQ_W'(search_hit_flag), 68'h1);
    chk("valid", DQ_W'(search_hit_flag_valid), 68'h0);
    chk("valid_oe", DQ_W'(search_hit_flag_valid_oe), 68'h0);
    host_model_inst.tick(1);
    @(posedge clk) begin
      last_device_bit <= 1'b1;
      device_position_code <= 5'h00;
    end
    // two-word burst over rows 5 and 6
    rd(TGT_MASK, 5'h00, 22'h5, 5'h1);
    host_model_inst.tick(1);
    #1;
    chk("eob", DQ_W'(end_of_burst_out), 68'h0);
    host_model_inst.tick(1);
    #1;
    chk("dq", dq_out, 68'hF0);
    chk("eob", DQ_W'(end_of_burst_out), 68'h1);
    chk("eob_oe", DQ_W'(end_of_burst_oe), 68'h1);
    host_model_inst.tick(2);
    rd(TGT_SRAM, 5'h00, 22'h2ABCD, 5'h0);
    #1;
    chk("result_memory_address", DQ_W'(result_memory_address), 68'h2ABCD);
    chk("ce_n", DQ_W'(sram_chip_enable_n), 68'h0);
    chk("ack", DQ_W'(read_ack), 68'h1);
    host_model_inst.tick(2);
    // direct memory write strobes the write line
    host_model_inst.send(mkcmd(CODE_WRITE, TGT_SRAM, 5'h0), adr(5'h00, 22'h1234), 1'b1);
    host_model_inst.idle();
    #1;
    chk("we_n", DQ_W'(sram_write_enable_n), 68'h0);
    chk("sram_oe", DQ_W'(sram_oe), 68'h1);
    chk("result_memory_address", DQ_W'(result_memory_address), 68'h1234);
    chk("ack", DQ_W'(read_ack), 68'h0);
    host_model_inst.tick(2);
    // upstream match outranks our own
    @(posedge clk) upstream_hit <= 1'b1;
    search(68'hA5, 1'b1);
    chk("hit", DQ_W'(search_hit_flag), 68'h0);
    chk("hit_oe", DQ_W'(search_hit_flag_oe), 68'h0);
    chk("sram_oe", DQ_W'(sram_oe), 68'h0);
    @(posedge clk) upstream_hit <= 1'b0;
    search(68'hA5, 1'b0);
    chk("valid", DQ_W'(search_hit_flag_valid), 68'h0);
    // learn fills the 14 empty rows
    for (int i = 0; i < 14; i++) begin
      chk("full", DQ_W'(table_full), 68'h0);
      host_model_inst.send(mkcmd(CODE_LEARN, 2'h0, 5'h0), 68'h100 | (DQ_W'(i) << 4), 1'b1);
      host_model_inst.idle();
      host_model_inst.tick(3);
    end
    for (int n = 0; n < 20 && table_full !== 1'b1; n++) host_model_inst.tick(1);
    #1;
    chk("full", DQ_W'(table_full), 68'h1);
    chk("full_out", DQ_W'(full_out), 68'h1);
    search(68'h101, 1'b1);
    chk("result_memory_address", DQ_W'(result_memory_address), 68'h0);
    // room upstream clears the chained full
    @(posedge clk) full_in <= 1'b0;
    host_model_inst.tick(2);
    #1;
    chk("full_out", DQ_W'(full_out), 68'h0);
    chk("full", DQ_W'(table_full), 68'h0);
    @(posedge clk) full_in <= 1'b1;
    // second reset clears the table
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk("full", DQ_W'(table_full), 68'h0);
    search(68'h101, 1'b1);
    chk("hit", DQ_W'(search_hit_flag), 68'h0);
    results();
  end
endmodule : tb
